// [include/csfa_pkg.sv]
// csfa_pkg: constants, carrier structs and enums for the stack/flags/addressing core.
// assumes a single system clock and a byte-wide memory with one-cycle read latency.
package csfa_pkg;

  // reset values and direct page high byte
  localparam logic [15:0] RST_SP    = 16'h00ff;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [7:0]  DIRECT_HI = 8'h00;

  // flag register bit positions; bits 6 and 5 read as one
  localparam int          CCR_V    = 7;
  localparam int          CCR_H    = 4;
  localparam int          CCR_I    = 3;
  localparam int          CCR_N    = 2;
  localparam int          CCR_Z    = 1;
  localparam int          CCR_C    = 0;
  localparam logic [7:0]  CCR_ONES = 8'h60;

  // last step index of each stacking sequence
  localparam logic [2:0]  LAST_ONE  = 3'h0;
  localparam logic [2:0]  LAST_CALL = 3'h1;
  localparam logic [2:0]  LAST_INT  = 3'h5;

  typedef enum logic [4:0] {
    CSFA_NOP, CSFA_PUSH_ACC, CSFA_PULL_ACC, CSFA_CALL_JUMP_OP, CSFA_CALL_BRANCH_OP,
    CSFA_RET, CSFA_RET_INT, CSFA_BRANCH, CSFA_LOAD, CSFA_ADD, CSFA_AND, CSFA_STORE,
    CSFA_MOVE, CSFA_LOAD_HX, CSFA_LOAD_SP, CSFA_SET_MASK, CSFA_CLR_MASK, CSFA_INT
  } csfa_op_t;

  typedef enum logic [2:0] {AM_IMM, AM_DIR, AM_EXT, AM_IX, AM_IX1, AM_SP1, AM_SP2, AM_REL} csfa_am_t;
  typedef enum logic [1:0] {MV_IMM_DIR, MV_DIR_DIR, MV_IXP_DIR, MV_DIR_IXP} csfa_mv_t;
  typedef enum logic [2:0] {BR_ALWAYS, BR_NEVER, BR_EQ, BR_NE, BR_MI, BR_PL, BR_CS, BR_CC} csfa_br_t;
  typedef enum logic [1:0] {ALU_PASS, ALU_ADD, ALU_AND} csfa_alu_fn_t;
  typedef enum {ST_IDLE, ST_PUSH, ST_PULL, ST_WAIT, ST_PCAP, ST_RCAP} csfa_st_t;

  typedef struct packed {
    logic v;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } csfa_flags_t;

  typedef struct packed {
    csfa_op_t    op;
    csfa_am_t    am;
    csfa_mv_t    mv;
    csfa_br_t    br;
    logic [1:0]  len;
    logic [7:0]  op8;
    logic [15:0] op16;
  } csfa_cmd_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } csfa_mem_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flag_register;
  } csfa_regs_t;

  typedef struct packed {
    csfa_st_t    st;
    logic [2:0]  step;
    csfa_cmd_t   cmd;
    logic [15:0] tgt;
    logic [7:0]  acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    csfa_flags_t flg;
    csfa_mem_t   mem;
    logic        ready;
    logic        done;
    logic        ack;
    logic        irq_s1;
    logic        irq_s2;
  } csfa_core_state_t;

  function automatic logic [7:0] ccr_pack(input csfa_flags_t f);
    logic [7:0] b;
    b        = CCR_ONES;
    b[CCR_V] = f.v;
    b[CCR_H] = f.h;
    b[CCR_I] = f.i;
    b[CCR_N] = f.n;
    b[CCR_Z] = f.z;
    b[CCR_C] = f.c;
    return b;
  endfunction

  function automatic csfa_flags_t ccr_unpack(input logic [7:0] b);
    csfa_flags_t f;
    f.v = b[CCR_V];
    f.h = b[CCR_H];
    f.i = b[CCR_I];
    f.n = b[CCR_N];
    f.z = b[CCR_Z];
    f.c = b[CCR_C];
    return f;
  endfunction

endpackage

// [hdl/csfa_alu.sv]
// csfa_alu: byte pass/add/and with negative, zero, half-carry, carry and overflow.
// assumes the caller picks the operands; purely combinational.
`timescale 1ns/1ps
module csfa_alu
  import csfa_pkg::*;
(
  input  wire csfa_alu_fn_t fn,
  input  wire [7:0]         a,
  input  wire [7:0]         b,
  input  wire csfa_flags_t  flg_in,
  output logic [7:0]        res,
  output csfa_flags_t       flg_out
);

  logic [8:0] sum;
  logic [4:0] half;

  always_comb begin
    sum     = {1'b0, a} + {1'b0, b};
    half    = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    flg_out = flg_in;
    case (fn)
      ALU_ADD: begin
        res       = sum[7:0];
        flg_out.c = sum[8];
        flg_out.h = half[4];
        flg_out.v = (a[7] == b[7]) && (sum[7] != a[7]);
      end
      ALU_AND: begin
        res       = a & b;
        flg_out.v = 1'b0;
      end
      default: begin
        res       = b;
        flg_out.v = 1'b0;
      end
    endcase
    flg_out.n = res[7];
    flg_out.z = (res == 8'h00);
  end

endmodule

// [hdl/csfa_core.sv]
// csfa_core: register set, stack engine, branch and operand address logic of a byte core.
// assumes commands arrive decoded from same-clock logic and memory answers a read one cycle later.
`timescale 1ns/1ps

// How it works
// - push writes at stack pointer, then decrements
// - pull increments stack pointer, then reads there
// - stack pointer always marks next empty byte
// - taken branch adds signed offset to counter
// - untaken branch keeps the advanced counter
// - negative result sets the negative flag
// - zero byte result sets the zero flag
// - call stacks return address low then high
// - return reloads counter from stacked address
// - interrupt entry stacks every register but the stack pointer
// - stack-relative operand is stack pointer plus offset
// - accumulator, index pair, stack pointer, counter kept
// - flag register holds v h i n z c
// - direct page is addresses 0x0000 to 0x00ff
// - four memory moves that bypass accumulator
// - counter points at next byte to fetch
// - writes drive data and strobe; reads strobe
// - mask bit set blocks maskable interrupts
module csfa_core
  import csfa_pkg::*;
(
  input  wire              clk,
  input  wire              rst_b,
  input  wire              cmd_valid,
  input  wire csfa_cmd_t   cmd,
  input  wire              irq_req_b,
  input  wire [15:0]       irq_vector,
  input  wire [7:0]        mem_rdata,
  output logic             cmd_ready,
  output logic             op_done,
  output logic             irq_ack,
  output csfa_mem_t        mem,
  output csfa_regs_t       regs
);

  csfa_core_state_t s_r;
  csfa_core_state_t s_nxt;
  logic             take;
  logic             fin;
  csfa_op_t         alu_op;
  csfa_alu_fn_t     alu_fn;
  logic [7:0]       alu_b;
  logic [7:0]       alu_res;
  csfa_flags_t      alu_flg;
  logic [15:0]      pc_adv;

  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // operand address of every addressing mode
  function automatic logic [15:0] ea_of(input csfa_am_t am, input logic [7:0] o8,
                                        input logic [15:0] o16, input logic [15:0] hx,
                                        input logic [15:0] sp);
    case (am)
      AM_DIR:  return {DIRECT_HI, o8};
      AM_EXT:  return o16;
      AM_IX:   return hx;
      AM_IX1:  return hx + {8'h00, o8};
      AM_SP1:  return sp + {8'h00, o8};
      AM_SP2:  return sp + o16;
      default: return o16;
    endcase
  endfunction

  function automatic logic br_true(input csfa_br_t br, input csfa_flags_t f);
    case (br)
      BR_ALWAYS: return 1'b1;
      BR_EQ:     return f.z;
      BR_NE:     return !f.z;
      BR_MI:     return f.n;
      BR_PL:     return !f.n;
      BR_CS:     return f.c;
      BR_CC:     return !f.c;
      default:   return 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] last_step(input csfa_op_t op);
    case (op)
      CSFA_CALL_JUMP_OP, CSFA_CALL_BRANCH_OP, CSFA_RET: return LAST_CALL;
      CSFA_INT, CSFA_RET_INT:                           return LAST_INT;
      default:                                          return LAST_ONE;
    endcase
  endfunction

  // stacking order: counter low, counter high, x, h, accumulator, flags
  function automatic logic [7:0] push_byte(input csfa_core_state_t s);
    if (s.cmd.op == CSFA_PUSH_ACC)
      return s.acc;
    case (s.step)
      3'h0:    return s.pc[7:0];
      3'h1:    return s.pc[15:8];
      3'h2:    return s.hx[7:0];
      3'h3:    return s.hx[15:8];
      3'h4:    return s.acc;
      default: return ccr_pack(s.flg);
    endcase
  endfunction

  assign take   = cmd_valid && s_r.ready;
  assign pc_adv = s_r.pc + {14'h0000, cmd.len};
  assign alu_op = (s_r.st == ST_IDLE) ? cmd.op : s_r.cmd.op;
  assign alu_fn = (alu_op == CSFA_ADD) ? ALU_ADD : (alu_op == CSFA_AND) ? ALU_AND : ALU_PASS;

  always_comb begin
    if (s_r.st != ST_IDLE)
      alu_b = mem_rdata;
    else if (cmd.op == CSFA_STORE)
      alu_b = s_r.acc;
    else
      alu_b = cmd.op8;
  end

  csfa_alu u_alu (
    .fn      (alu_fn),
    .a       (s_r.acc),
    .b       (alu_b),
    .flg_in  (s_r.flg),
    .res     (alu_res),
    .flg_out (alu_flg)
  );

  always_comb begin
    s_nxt        = s_r;
    fin          = 1'b0;
    s_nxt.mem.we = 1'b0;
    s_nxt.mem.re = 1'b0;
    s_nxt.done   = 1'b0;
    s_nxt.ack    = 1'b0;
    s_nxt.irq_s1 = irq_req_b;
    s_nxt.irq_s2 = s_r.irq_s1;
    case (s_r.st)
      ST_IDLE: begin
        if (take) begin
          s_nxt.cmd   = cmd;
          s_nxt.ready = 1'b0;
          s_nxt.step  = 3'h0;
          s_nxt.pc    = pc_adv;
          s_nxt.tgt   = ea_of(cmd.am, cmd.op8, cmd.op16, s_r.hx, s_r.sp);
          case (cmd.op)
            CSFA_BRANCH: begin
              if (br_true(cmd.br, s_r.flg))
                s_nxt.pc = pc_adv + sext8(cmd.op8);
              fin = 1'b1;
            end
            CSFA_CALL_JUMP_OP:   s_nxt.st = ST_PUSH;
            CSFA_CALL_BRANCH_OP: begin
              s_nxt.tgt = pc_adv + sext8(cmd.op8);
              s_nxt.st  = ST_PUSH;
            end
            CSFA_PUSH_ACC:                       s_nxt.st = ST_PUSH;
            CSFA_PULL_ACC, CSFA_RET, CSFA_RET_INT: s_nxt.st = ST_PULL;
            CSFA_LOAD, CSFA_ADD, CSFA_AND: begin
              if (cmd.am == AM_IMM) begin
                s_nxt.acc = alu_res;
                s_nxt.flg = alu_flg;
                fin       = 1'b1;
              end else begin
                s_nxt.mem.re   = 1'b1;
                s_nxt.mem.addr = ea_of(cmd.am, cmd.op8, cmd.op16, s_r.hx, s_r.sp);
                s_nxt.st       = ST_WAIT;
              end
            end
            CSFA_STORE: begin
              s_nxt.mem.we    = 1'b1;
              s_nxt.mem.addr  = ea_of(cmd.am, cmd.op8, cmd.op16, s_r.hx, s_r.sp);
              s_nxt.mem.wdata = s_r.acc;
              s_nxt.flg       = alu_flg;
              fin             = 1'b1;
            end
            CSFA_MOVE: begin
              // source fetched straight to the bus, accumulator untouched
              case (cmd.mv)
                MV_IMM_DIR: begin
                  s_nxt.mem.we    = 1'b1;
                  s_nxt.mem.addr  = {DIRECT_HI, cmd.op16[7:0]};
                  s_nxt.mem.wdata = cmd.op8;
                  s_nxt.flg       = alu_flg;
                  fin             = 1'b1;
                end
                MV_IXP_DIR: begin
                  s_nxt.mem.re   = 1'b1;
                  s_nxt.mem.addr = s_r.hx;
                  s_nxt.st       = ST_WAIT;
                end
                default: begin
                  s_nxt.mem.re   = 1'b1;
                  s_nxt.mem.addr = {DIRECT_HI, cmd.op8};
                  s_nxt.st       = ST_WAIT;
                end
              endcase
            end
            CSFA_LOAD_HX: begin
              s_nxt.hx = cmd.op16;
              fin      = 1'b1;
            end
            CSFA_LOAD_SP: begin
              s_nxt.sp = cmd.op16;
              fin      = 1'b1;
            end
            CSFA_SET_MASK: begin
              s_nxt.flg.i = 1'b1;
              fin         = 1'b1;
            end
            CSFA_CLR_MASK: begin
              s_nxt.flg.i = 1'b0;
              fin         = 1'b1;
            end
            default: fin = 1'b1;
          endcase
        end else if (!s_r.irq_s2 && !s_r.flg.i) begin
          // commands win a tie; the request stays pending until the next free cycle
          s_nxt.cmd.op = CSFA_INT;
          s_nxt.tgt    = irq_vector;
          s_nxt.step   = 3'h0;
          s_nxt.ready  = 1'b0;
          s_nxt.ack    = 1'b1;
          s_nxt.st     = ST_PUSH;
        end
      end
      ST_PUSH: begin
        s_nxt.mem.we    = 1'b1;
        s_nxt.mem.addr  = s_r.sp;
        s_nxt.mem.wdata = push_byte(s_r);
        s_nxt.sp        = s_r.sp - 16'h0001;
        s_nxt.step      = s_r.step + 3'h1;
        if (s_r.step == last_step(s_r.cmd.op)) begin
          fin = 1'b1;
          if (s_r.cmd.op == CSFA_INT) begin
            s_nxt.pc    = s_r.tgt;
            s_nxt.flg.i = 1'b1;
          end else if (s_r.cmd.op != CSFA_PUSH_ACC) begin
            s_nxt.pc = s_r.tgt;
          end
        end
      end
      ST_PULL: begin
        s_nxt.sp       = s_r.sp + 16'h0001;
        s_nxt.mem.re   = 1'b1;
        s_nxt.mem.addr = s_r.sp + 16'h0001;
        s_nxt.st       = ST_WAIT;
      end
      ST_WAIT: begin
        if (s_r.cmd.op inside {CSFA_PULL_ACC, CSFA_RET, CSFA_RET_INT})
          s_nxt.st = ST_PCAP;
        else
          s_nxt.st = ST_RCAP;
      end
      ST_PCAP: begin
        case (s_r.cmd.op)
          CSFA_RET: begin
            if (s_r.step == 3'h0)
              s_nxt.pc[15:8] = mem_rdata;
            else
              s_nxt.pc[7:0] = mem_rdata;
          end
          CSFA_RET_INT: begin
            case (s_r.step)
              3'h0:    s_nxt.flg = ccr_unpack(mem_rdata);
              3'h1:    s_nxt.acc = mem_rdata;
              3'h2:    s_nxt.hx[15:8] = mem_rdata;
              3'h3:    s_nxt.hx[7:0] = mem_rdata;
              3'h4:    s_nxt.pc[15:8] = mem_rdata;
              default: s_nxt.pc[7:0] = mem_rdata;
            endcase
          end
          default: s_nxt.acc = mem_rdata;
        endcase
        if (s_r.step == last_step(s_r.cmd.op)) begin
          fin = 1'b1;
        end else begin
          s_nxt.step = s_r.step + 3'h1;
          s_nxt.st   = ST_PULL;
        end
      end
      ST_RCAP: begin
        s_nxt.flg = alu_flg;
        fin       = 1'b1;
        if (s_r.cmd.op == CSFA_MOVE) begin
          s_nxt.mem.we    = 1'b1;
          s_nxt.mem.wdata = mem_rdata;
          case (s_r.cmd.mv)
            MV_DIR_IXP: s_nxt.mem.addr = s_r.hx;
            MV_IXP_DIR: s_nxt.mem.addr = {DIRECT_HI, s_r.cmd.op8};
            default:    s_nxt.mem.addr = {DIRECT_HI, s_r.cmd.op16[7:0]};
          endcase
          if (s_r.cmd.mv inside {MV_DIR_IXP, MV_IXP_DIR})
            s_nxt.hx = s_r.hx + 16'h0001;
        end else begin
          s_nxt.acc = alu_res;
        end
      end
      default: fin = 1'b1;
    endcase
    if (fin) begin
      s_nxt.st    = ST_IDLE;
      s_nxt.done  = 1'b1;
      s_nxt.ready = 1'b1;
    end
  end

  // sync flops reset to the idle level of the request pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r        <= '0;
      s_r.sp     <= RST_SP;
      s_r.pc     <= RST_PC;
      s_r.flg.i  <= 1'b1;
      s_r.ready  <= 1'b1;
      s_r.irq_s1 <= 1'b1;
      s_r.irq_s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_ready = s_r.ready;
  assign op_done   = s_r.done;
  assign irq_ack   = s_r.ack;
  assign mem       = s_r.mem;
  assign regs      = '{acc: s_r.acc, hx: s_r.hx, sp: s_r.sp, pc: s_r.pc, flag_register: ccr_pack(s_r.flg)};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_push_order;
    s_r.st == ST_PUSH |=> s_r.mem.we && s_r.mem.addr == $past(s_r.sp) && s_r.sp == $past(s_r.sp) - 16'h0001;
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order wrong");

  property p_pull_order;
    s_r.st == ST_PULL |=> s_r.mem.re && s_r.mem.addr == $past(s_r.sp) + 16'h0001 && s_r.sp == s_r.mem.addr;
  endproperty
  a_pull_order: assert property (p_pull_order) else $error("pull order wrong");

  property p_sp_empty;
    $past(s_r.st == ST_PUSH) |-> s_r.sp + 16'h0001 == s_r.mem.addr;
  endproperty
  a_sp_empty: assert property (p_sp_empty) else $error("stack pointer not at empty byte");

  property p_branch_taken;
    take && cmd.op == CSFA_BRANCH && br_true(cmd.br, s_r.flg)
      |=> s_r.pc == $past(s_r.pc + {14'h0000, cmd.len} + sext8(cmd.op8));
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("taken branch target wrong");

  property p_branch_not;
    take && cmd.op == CSFA_BRANCH && !br_true(cmd.br, s_r.flg) |=> s_r.pc == $past(pc_adv);
  endproperty
  a_branch_not: assert property (p_branch_not) else $error("untaken branch moved counter");

  property p_neg_flag;
    s_r.st == ST_RCAP && s_r.cmd.op == CSFA_LOAD |=> s_r.acc == $past(mem_rdata) && s_r.flg.n == s_r.acc[7];
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");

  property p_zero_flag;
    s_r.st == ST_RCAP && s_r.cmd.op == CSFA_LOAD |=> s_r.flg.z == (s_r.acc == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_call_stack;
    s_r.st == ST_PUSH && s_r.step == 3'h0 && s_r.cmd.op inside {CSFA_CALL_JUMP_OP, CSFA_CALL_BRANCH_OP}
      |=> s_r.mem.wdata == s_r.pc[7:0] ##1 s_r.mem.wdata == $past(s_r.pc[15:8]) && s_r.pc == s_r.tgt;
  endproperty
  a_call_stack: assert property (p_call_stack) else $error("call stacking order wrong");

  property p_ret_load;
    s_r.st == ST_PCAP && s_r.cmd.op == CSFA_RET && s_r.step == 3'h1
      |=> s_r.pc == {$past(s_r.pc[15:8]), $past(mem_rdata)} && s_r.done;
  endproperty
  a_ret_load: assert property (p_ret_load) else $error("return address not restored");

  property p_int_stack;
    s_r.ack |=> s_r.mem.we [*6] ##0 (s_r.flg.i && s_r.pc == s_r.tgt && s_r.done);
  endproperty
  a_int_stack: assert property (p_int_stack) else $error("interrupt stacking wrong");

  property p_sp_rel;
    take && cmd.op == CSFA_LOAD && cmd.am == AM_SP1 |=> s_r.mem.re && s_r.mem.addr == $past(s_r.sp + {8'h00, cmd.op8});
  endproperty
  a_sp_rel: assert property (p_sp_rel) else $error("stack relative address wrong");

  property p_direct;
    take && cmd.am == AM_DIR && cmd.op inside {CSFA_LOAD, CSFA_ADD, CSFA_AND} |=> s_r.mem.addr[15:8] == DIRECT_HI;
  endproperty
  a_direct: assert property (p_direct) else $error("direct address outside page");

  property p_strobes;
    !(s_r.mem.we && s_r.mem.re);
  endproperty
  a_strobes: assert property (p_strobes) else $error("read and write strobes together");

  property p_mask;
    s_r.ack |-> !$past(s_r.flg.i);
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt taken while masked");

  c_call: cover property (take && cmd.op == CSFA_CALL_JUMP_OP ##3 s_r.done);
  c_int: cover property (s_r.ack ##6 s_r.done);
  c_move: cover property (take && cmd.op == CSFA_MOVE && cmd.mv == MV_DIR_IXP ##3 s_r.mem.we);
  c_branch: cover property (take && cmd.op == CSFA_BRANCH && cmd.op8[7]);

endmodule

// [test/csfa_mem_model.sv]
// csfa_mem_model: byte-wide memory that stands on the core's address/data bus.
// assumes one clock, answer in the cycle after a read strobe, no wait states.
`timescale 1ns/1ps
module csfa_mem_model
  import csfa_pkg::*;
(
  input  wire             clk,
  input  wire csfa_mem_t  mem,
  output logic [7:0]      mem_rdata
);
  logic [7:0] m [0:65535];
  logic [7:0] rd_q;
  logic       rd_v;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      m[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
    end
    rd_q = 8'h00;
    rd_v = 1'b0;
  end

  always @(posedge clk) begin
    if (mem.we === 1'b1) begin
      m[mem.addr] <= mem.wdata;
    end
    rd_v <= (mem.re === 1'b1);
    if (mem.re === 1'b1) begin
      rd_q <= m[mem.addr];
    end
  end

  // outside the answer cycle the bus shows no stale byte
  assign mem_rdata = rd_v ? rd_q : ~rd_q;
endmodule

// [test/cpu_stack_flags_addressing_test.sv]
// cpu_stack_flags_addressing_test: self-checking bench for csfa_core with a memory model.
// assumes registered outputs that settle between edges; notes are checked at op_done.
`timescale 1ns/1ps
module cpu_stack_flags_addressing_test;
  import csfa_pkg::*;
  typedef struct packed {logic [7:0] acc; logic [15:0] sp; logic [15:0] pc; logic n; logic z; logic i;} csfa_note_t;
  logic        clk, rst_b, cmd_valid, irq_req_b, cmd_ready, op_done, irq_ack;
  csfa_cmd_t   cmd, cc;
  logic [15:0] irq_vector;
  logic [7:0]  mem_rdata;
  csfa_mem_t   mem;
  csfa_regs_t  regs;
  csfa_note_t  notes [$];
  csfa_note_t  nt;
  int          err_total, compares, acks;
  logic [7:0]  e_acc, v, sv;
  logic [15:0] e_sp, e_pc, sp0, ret, pcs;
  logic        e_n, e_z, e_i, tk;

  csfa_core uut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .irq_req_b(irq_req_b),
    .irq_vector(irq_vector), .mem_rdata(mem_rdata), .cmd_ready(cmd_ready), .op_done(op_done),
    .irq_ack(irq_ack), .mem(mem), .regs(regs));
  csfa_mem_model mm (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic csfa_cmd_t mk(csfa_op_t o, csfa_am_t a, csfa_br_t b, logic [1:0] l, logic [7:0] d8,
                                   logic [15:0] d16);
    return '{op: o, am: a, mv: MV_IMM_DIR, br: b, len: l, op8: d8, op16: d16};
  endfunction

  task automatic wait_done();
    int n;
    for (n = 0; n < 40 && op_done !== 1'b1; n++) begin
      @(posedge clk);
      #2;
    end
    if (n == 40) chk(16'h0001, 16'h0000, "no completion");
    // one more edge so a write launched with op_done has landed
    @(posedge clk);
    #2;
  endtask

  // expected state is set by the caller before the command goes out
  task automatic issue(input csfa_cmd_t c);
    notes.push_back('{e_acc, e_sp, e_pc, e_n, e_z, e_i});
    cmd = c;
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #2 cmd_valid = 1'b0;
    wait_done();
  endtask

  always @(posedge clk) begin
    if (irq_ack === 1'b1) acks++;
    if (op_done === 1'b1) begin
      if (notes.size() == 0) chk(16'h0001, 16'h0000, "unexpected completion");
      else begin
        nt = notes.pop_front();
        chk(regs.acc, nt.acc, "acc");
        chk(regs.sp, nt.sp, "sp");
        chk(regs.pc, nt.pc, "pc");
        chk(regs.flag_register[CCR_N], nt.n, "neg flag");
        chk(regs.flag_register[CCR_Z], nt.z, "zero flag");
        chk(regs.flag_register[CCR_I], nt.i, "mask flag");
      end
    end
  end

  initial begin
    #(100 * 5000);
    err_total++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0; cmd_valid = 1'b0; cmd = '0; irq_req_b = 1'b1; irq_vector = 16'h2468;
    err_total = 0; compares = 0; acks = 0;
    void'($urandom(62));
    e_acc = 8'h00; e_sp = 16'h00ff; e_pc = 16'h0000; e_n = 1'b0; e_z = 1'b0; e_i = 1'b1;
    repeat (5) @(posedge clk);
    #2 rst_b = 1'b1;
    chk(regs.sp, 16'h00ff, "reset sp");
    chk({8'h00, regs.flag_register}, 16'h0068, "reset flags");
    chk(regs.pc, 16'h0000, "reset pc");
    @(posedge clk);
    #2;
    e_sp = 16'h01f0; e_pc += 3;
    issue(mk(CSFA_LOAD_SP, AM_IMM, BR_NEVER, 2'd3, 8'h00, 16'h01f0));
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : (k == 2) ? 8'h7f : 8'($urandom_range(1, 255));
      e_acc = v; e_n = v[7]; e_z = (v == 8'h00); e_pc += 2;
      issue(mk(CSFA_LOAD, AM_IMM, BR_NEVER, 2'd2, v, 16'h0000));
    end
    sv = e_acc; sp0 = e_sp; e_sp -= 1; e_pc += 1;
    issue(mk(CSFA_PUSH_ACC, AM_IMM, BR_NEVER, 2'd1, 8'h00, 16'h0000));
    chk({8'h00, mm.m[sp0]}, {8'h00, sv}, "pushed byte");
    e_acc = 8'h00; e_n = 1'b0; e_z = 1'b1; e_pc += 2;
    issue(mk(CSFA_LOAD, AM_IMM, BR_NEVER, 2'd2, 8'h00, 16'h0000));
    e_acc = sv; e_sp += 1; e_pc += 1;
    issue(mk(CSFA_PULL_ACC, AM_IMM, BR_NEVER, 2'd1, 8'h00, 16'h0000));
    for (int k = 0; k < 2; k++) begin
      sp0 = e_sp; e_sp -= 2;
      if (k == 0) begin
        ret = e_pc + 16'd3; e_pc = 16'h1234;
        issue(mk(CSFA_CALL_JUMP_OP, AM_EXT, BR_NEVER, 2'd3, 8'h00, 16'h1234));
      end else begin
        ret = e_pc + 16'd2; e_pc = ret + 16'hfff0;
        issue(mk(CSFA_CALL_BRANCH_OP, AM_REL, BR_NEVER, 2'd2, 8'hf0, 16'h0000));
      end
      chk({8'h00, mm.m[sp0]}, {8'h00, ret[7:0]}, "return low");
      chk({8'h00, mm.m[sp0 - 16'd1]}, {8'h00, ret[15:8]}, "return high");
      e_sp += 2; e_pc = ret;
      issue(mk(CSFA_RET, AM_IMM, BR_NEVER, 2'd1, 8'h00, 16'h0000));
    end
    for (int k = 0; k < 8; k++) begin
      v = (k == 7) ? 8'h80 : 8'($urandom);
      case (csfa_br_t'(k))
        BR_ALWAYS: tk = 1'b1;
        BR_NEVER:  tk = 1'b0;
        BR_EQ:     tk = e_z;
        BR_NE:     tk = ~e_z;
        BR_MI:     tk = e_n;
        BR_PL:     tk = ~e_n;
        BR_CS:     tk = 1'b0;
        default:   tk = 1'b1;
      endcase
      e_pc = e_pc + 16'd2 + (tk ? {{8{v[7]}}, v} : 16'h0000);
      issue(mk(CSFA_BRANCH, AM_REL, csfa_br_t'(k), 2'd2, v, 16'h0000));
    end
    v = 8'($urandom);
    e_acc = mm.m[e_sp + {8'h00, v}]; e_n = e_acc[7]; e_z = (e_acc == 8'h00); e_pc += 2;
    issue(mk(CSFA_LOAD, AM_SP1, BR_NEVER, 2'd2, v, 16'h0000));
    for (int k = 0; k < 2; k++) begin
      v = 8'($urandom);
      e_acc = (k == 0) ? e_acc + v : e_acc & v;
      e_n = e_acc[7];
      e_z = (e_acc == 8'h00);
      e_pc += 2;
      issue(mk(k == 0 ? CSFA_ADD : CSFA_AND, AM_IMM, BR_NEVER, 2'd2, v, 16'h0000));
    end
    e_pc += 2;
    issue(mk(CSFA_STORE, AM_DIR, BR_NEVER, 2'd2, 8'h50, 16'h0000));
    chk({8'h00, mm.m[16'h0050]}, {8'h00, e_acc}, "stored byte");
    v = 8'($urandom_range(1, 255));
    e_n = v[7]; e_z = 1'b0; e_pc += 3;
    issue(mk(CSFA_MOVE, AM_IMM, BR_NEVER, 2'd3, v, 16'hab42));
    chk({8'h00, mm.m[16'h0042]}, {8'h00, v}, "moved byte");
    e_pc += 3;
    issue(mk(CSFA_LOAD_HX, AM_IMM, BR_NEVER, 2'd3, 8'h00, 16'h0030));
    cc = mk(CSFA_MOVE, AM_DIR, BR_NEVER, 2'd2, 8'h42, 16'h0000);
    cc.mv = MV_DIR_IXP;
    e_pc += 2;
    issue(cc);
    chk({8'h00, mm.m[16'h0030]}, {8'h00, v}, "moved to index");
    chk(regs.hx, 16'h0031, "index post increment");
    irq_req_b = 1'b0;
    repeat (20) @(posedge clk);
    #2 chk(acks[15:0], 16'h0000, "masked request");
    irq_req_b = 1'b1;
    repeat (3) @(posedge clk);
    #2 e_i = 1'b0; e_pc += 1;
    issue(mk(CSFA_CLR_MASK, AM_IMM, BR_NEVER, 2'd1, 8'h00, 16'h0000));
    sp0 = e_sp; pcs = e_pc; e_sp -= 6; e_pc = irq_vector; e_i = 1'b1;
    notes.push_back('{e_acc, e_sp, e_pc, e_n, e_z, e_i});
    irq_req_b = 1'b0;
    @(posedge clk);
    #2 wait_done();
    irq_req_b = 1'b1;
    chk(acks[15:0], 16'h0001, "interrupt taken");
    chk({mm.m[sp0 - 16'd1], mm.m[sp0]}, pcs, "stacked pc");
    chk({8'h00, mm.m[sp0 - 16'd4]}, {8'h00, e_acc}, "stacked acc");
    chk({15'h0000, mm.m[sp0 - 16'd5][CCR_I]}, 16'h0000, "stacked mask");
    e_sp += 6; e_pc = pcs; e_i = 1'b0;
    issue(mk(CSFA_RET_INT, AM_IMM, BR_NEVER, 2'd1, 8'h00, 16'h0000));
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule
